// ==== hw/cdrsv_pkg.sv ====
// What this block does
// R1: reference is line rate over 16, 32, 128
// R2: divide recovered clock, compare against reference
// R3: deviation beyond threshold raises lock lost flag
// R4: retry acquisition periodically while out of lock
// R5: reacquisition drift held within +-600 ppm
// R6: flag stays high until frequency returns
// R7: flag held low during power down
// R8: power down parks data and clock pairs
// R9: release resets logic, calibrates if the power down hold reached PD_HOLD_LAST, then acquires
// R10: no data: clock output follows reference
// R11: data changes only on recovered clock rise
// R12: host rate select sets divider 1/2/4/16
// R13: host holds power down 1 us minimum
// R14: lock threshold is a design parameter
package cdrsv_pkg;

    // system clock timing
    localparam int SYS_PERIOD_NS   = 100;
    localparam int TMR_W           = 16;
    localparam int PD_HOLD_MIN_NS  = 1000;
    localparam int PD_HOLD_MIN_CYC = (PD_HOLD_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int CAL_TIME_NS     = 2000;
    localparam int CAL_CYC         = (CAL_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int RETRY_PERIOD_NS = 100000;
    localparam int RETRY_CYC       = RETRY_PERIOD_NS / SYS_PERIOD_NS;

    localparam logic [TMR_W-1:0] PD_HOLD_LAST = TMR_W'(PD_HOLD_MIN_CYC);
    localparam logic [TMR_W-1:0] CAL_LAST     = TMR_W'(CAL_CYC - 1);
    localparam logic [TMR_W-1:0] RETRY_LAST   = TMR_W'(RETRY_CYC - 1);

    // frequency measurement
    localparam int                CNT_W           = 10;
    localparam logic [CNT_W-1:0]  LOCK_WIN_EDGES  = 10'h040;
    localparam logic [CNT_W-1:0]  LOCK_WIN_LAST   = 10'h03f;
    localparam logic [CNT_W-1:0]  LOCK_THRESH_DEF = 10'h004;
    localparam int                PRE_W           = 7;

    // reacquisition trim, in ppm
    localparam int                      TRIM_W     = 11;
    localparam logic signed [TRIM_W-1:0] PPM_LIMIT = 11'sh258;
    localparam logic signed [TRIM_W-1:0] PPM_STEP  = 11'sh032;

    // reference ratio codes and their log2
    localparam logic [1:0] RATIO_16  = 2'h0;
    localparam logic [1:0] RATIO_32  = 2'h1;
    localparam logic [1:0] RATIO_128 = 2'h2;
    localparam logic [2:0] LOG_16    = 3'h4;
    localparam logic [2:0] LOG_32    = 3'h5;
    localparam logic [2:0] LOG_128   = 3'h7;

    // rate select codes and log2 of output divider
    localparam logic [1:0] RATE_DIV1  = 2'h0;
    localparam logic [1:0] RATE_DIV2  = 2'h2;
    localparam logic [1:0] RATE_DIV4  = 2'h1;
    localparam logic [1:0] RATE_DIV16 = 2'h3;
    localparam logic [2:0] LOG_DIV1   = 3'h0;
    localparam logic [2:0] LOG_DIV2   = 3'h1;
    localparam logic [2:0] LOG_DIV4   = 3'h2;
    localparam logic [2:0] LOG_DIV16  = 3'h4;

    localparam int SYNC_W  = 7;
    localparam int FIFO_W  = 1;

    typedef enum logic [1:0] {
        ST_PDN = 2'b00,
        ST_CAL = 2'b01,
        ST_RUN = 2'b10
    } cdrsv_state_t;

endpackage : cdrsv_pkg

// ==== hw/cdrsv_sync.sv ====
`timescale 1ns/100ps
module cdrsv_sync #(
    parameter int W = 1
) (
    input  wire logic         i_sys_clk,  // system clock
    input  wire logic         i_srst,     // sync reset
    input  wire logic [W-1:0] i_async,    // asynchronous levels
    output logic      [W-1:0] o_sync      // synchronised levels
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } cdrsv_sync_st_t;

    cdrsv_sync_st_t st_ff;
    cdrsv_sync_st_t nxt_st;

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.stage1 = i_async;
        nxt_st.stage2 = st_ff.stage1;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_sync = st_ff.stage2;

endmodule : cdrsv_sync

// ==== hw/cdrsv_fifo.sv ====
`timescale 1ns/100ps
module cdrsv_fifo #(
    parameter int W = 1
) (
    input  wire logic         i_sys_clk,   // system clock
    input  wire logic         i_srst,      // sync reset
    input  wire logic         i_flush,     // drop all entries
    input  wire logic [W-1:0] i_in_data,   // write data
    input  wire logic         i_in_valid,  // write valid
    output logic              o_in_ready,  // space available
    output logic      [W-1:0] o_out_data,  // head data
    output logic              o_out_valid, // head valid
    input  wire logic         i_out_ready  // head taken
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              wptr;
        logic              rptr;
        logic [1:0]        cnt;
        logic              rdy;
    } cdrsv_fifo_st_t;

    cdrsv_fifo_st_t st_ff;
    cdrsv_fifo_st_t nxt_st;
    logic           push;
    logic           pop;

    always_comb begin
        nxt_st = st_ff;
        push   = i_in_valid && st_ff.rdy;
        pop    = (st_ff.cnt != 2'h0) && i_out_ready;
        if (push) begin
            nxt_st.mem[st_ff.wptr] = i_in_data;
            nxt_st.wptr            = ~st_ff.wptr;
        end
        if (pop) begin
            nxt_st.rptr = ~st_ff.rptr;
        end
        if (push && !pop) begin
            nxt_st.cnt = st_ff.cnt + 2'h1;
        end else if (pop && !push) begin
            nxt_st.cnt = st_ff.cnt - 2'h1;
        end
        if (i_flush) begin
            nxt_st.cnt  = 2'h0;
            nxt_st.wptr = 1'b0;
            nxt_st.rptr = 1'b0;
        end
        // ready registered so a stall reaches the source
        nxt_st.rdy = (nxt_st.cnt != 2'h2);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_in_ready  = st_ff.rdy;
    assign o_out_valid = (st_ff.cnt != 2'h0);
    assign o_out_data  = st_ff.mem[st_ff.rptr];

endmodule : cdrsv_fifo

// ==== hw/cdrsv_top.sv ====
`timescale 1ns/100ps
module cdrsv_top #(
    parameter logic [cdrsv_pkg::CNT_W-1:0] LOCK_THRESH = cdrsv_pkg::LOCK_THRESH_DEF
) (
    input  wire logic        i_sys_clk,                // 10 MHz system clock
    input  wire logic        i_srst,                   // sync reset, high
    input  wire logic        i_reference_clock_in,     // reference clock pin
    input  wire logic        i_recov_clk,              // recovered clock from loop
    input  wire logic        i_powerdown_calibrate_in, // power down / calibrate pin
    input  wire logic [1:0]  i_rate_select,            // output divider select
    input  wire logic [1:0]  i_ref_ratio,              // detected reference ratio
    input  wire logic        i_data_present,           // line activity seen
    input  wire logic        i_rx_data,                // recovered data bit
    input  wire logic        i_rx_valid,               // data bit valid
    output logic             o_rx_ready,               // buffer accepts bit
    output logic             o_lock_lost_flag,         // loss of lock
    output logic             o_recovered_clock_out_p,  // clock pair, true
    output logic             o_recovered_clock_out_n,  // clock pair, complement
    output logic             o_data_out_p,             // data pair, true
    output logic             o_data_out_n,             // data pair, complement
    output logic             o_calibrating,            // loop calibration running
    output logic             o_reacquire,              // retry pulse
    output logic signed [cdrsv_pkg::TRIM_W-1:0] o_vco_trim_ppm // drift offset
);
    import cdrsv_pkg::*;

    typedef struct packed {
        cdrsv_state_t             state;
        logic [TMR_W-1:0]         tmr;
        logic [TMR_W-1:0]         hold;
        logic                     ref_prev;
        logic                     rec_prev;
        logic [PRE_W-1:0]         pre;
        logic [CNT_W-1:0]         ref_cnt;
        logic [CNT_W-1:0]         rec_cnt;
        logic                     lock_lost_flag;
        logic signed [TRIM_W-1:0] trim;
        logic                     trim_down;
        logic                     reacq;
        logic                     cal;
        logic                     clk_lvl;
        logic                     clk_p;
        logic                     clk_n;
        logic                     dat_p;
        logic                     dat_n;
    } cdrsv_top_st_t;

    cdrsv_top_st_t st_ff;
    cdrsv_top_st_t nxt_st;

    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_out;
    logic              ref_s;
    logic              rec_s;
    logic              pd_s;
    logic              present_s;
    logic [1:0]        rate_s;
    logic [1:0]        ratio_s;
    logic              fifo_data;
    logic              fifo_valid;
    logic              fifo_pop;
    logic              fifo_flush;
    logic              ref_rise;
    logic              rec_rise;
    logic              src_clk;
    logic [PRE_W-1:0]  div_last;
    logic [CNT_W-1:0]  dev;
    logic signed [TRIM_W-1:0] trim_try;

    function automatic logic [2:0] ratio_log2(input logic [1:0] code);
        logic [2:0] r;
        r = LOG_16;
        if (code == RATIO_32) begin
            r = LOG_32;
        end else if (code == RATIO_128) begin
            r = LOG_128;
        end
        return r;
    endfunction : ratio_log2

    function automatic logic [2:0] rate_log2(input logic [1:0] code);
        logic [2:0] r;
        r = LOG_DIV1;
        if (code == RATE_DIV2) begin
            r = LOG_DIV2;
        end else if (code == RATE_DIV4) begin
            r = LOG_DIV4;
        end else if (code == RATE_DIV16) begin
            r = LOG_DIV16;
        end
        return r;
    endfunction : rate_log2

    // recovered clock edges per reference edge, minus one
    function automatic logic [PRE_W-1:0] div_count(input logic [1:0] ratio, input logic [1:0] rate);
        logic [2:0]       lr;
        logic [2:0]       ld;
        logic [2:0]       sh;
        logic [PRE_W-1:0] one;
        lr  = ratio_log2(ratio);
        ld  = rate_log2(rate);
        sh  = (ld > lr) ? 3'h0 : 3'(lr - ld);
        one = PRE_W'(1);
        return PRE_W'((one << sh) - one);
    endfunction : div_count

    assign sync_in = {i_reference_clock_in, i_recov_clk, ~i_powerdown_calibrate_in,
                      i_data_present, i_rate_select, i_ref_ratio[1]};

    cdrsv_sync #(
        .W (SYNC_W)
    ) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_async   (sync_in),
        .o_sync    (sync_out)
    );

    // low ratio bit synchronised separately to keep the bus tidy
    logic ratio0_s;

    cdrsv_sync #(
        .W (1)
    ) u_sync_ratio0 (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_async   (i_ref_ratio[0]),
        .o_sync    (ratio0_s)
    );

    assign ref_s     = sync_out[6];
    assign rec_s     = sync_out[5];
    // synced inverted so reset reads as power down
    assign pd_s      = ~sync_out[4];
    assign present_s = sync_out[3];
    assign rate_s    = sync_out[2:1];
    assign ratio_s   = {sync_out[0], ratio0_s};

    cdrsv_fifo #(
        .W (FIFO_W)
    ) u_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_srst      (i_srst),
        .i_flush     (fifo_flush),
        .i_in_data   (i_rx_data),
        .i_in_valid  (i_rx_valid),
        .o_in_ready  (o_rx_ready),
        .o_out_data  (fifo_data),
        .o_out_valid (fifo_valid),
        .i_out_ready (fifo_pop)
    );

    assign ref_rise = ref_s & ~st_ff.ref_prev;
    assign rec_rise = rec_s & ~st_ff.rec_prev;
    // R10 reference drives clock without data
    assign src_clk  = present_s ? rec_s : ref_s;
    // R1 R2 divider from ratio and rate
    assign div_last = div_count(ratio_s, rate_s);
    assign dev      = (st_ff.rec_cnt >= LOCK_WIN_EDGES) ? (st_ff.rec_cnt - LOCK_WIN_EDGES)
                                                       : (LOCK_WIN_EDGES - st_ff.rec_cnt);
    assign trim_try = st_ff.trim_down ? (st_ff.trim - PPM_STEP) : (st_ff.trim + PPM_STEP);

    always_comb begin
        nxt_st          = st_ff;
        nxt_st.ref_prev = ref_s;
        nxt_st.rec_prev = rec_s;
        nxt_st.reacq    = 1'b0;
        fifo_pop        = 1'b0;
        fifo_flush      = 1'b1;
        case (st_ff.state)
            ST_PDN: begin
                // R8 pairs parked high
                nxt_st.clk_p = 1'b1;
                nxt_st.clk_n = 1'b1;
                nxt_st.dat_p = 1'b1;
                nxt_st.dat_n = 1'b1;
                nxt_st.lock_lost_flag   = 1'b0;
                nxt_st.cal   = 1'b0;
                if (st_ff.hold != PD_HOLD_LAST) begin
                    nxt_st.hold = st_ff.hold + TMR_W'(1);
                end
                if (!pd_s) begin
                    // R9 logic reset on release
                    nxt_st.tmr       = '0;
                    nxt_st.pre       = '0;
                    nxt_st.ref_cnt   = '0;
                    nxt_st.rec_cnt   = '0;
                    nxt_st.trim      = '0;
                    nxt_st.trim_down = 1'b0;
                    nxt_st.clk_lvl   = 1'b0;
                    // R13 short pulse skips calibration
                    if (st_ff.hold == PD_HOLD_LAST) begin
                        nxt_st.state = ST_CAL;
                        nxt_st.cal   = 1'b1;
                    end else begin
                        nxt_st.state = ST_RUN;
                    end
                end
            end
            ST_CAL: begin
                // R9 calibrate before acquiring
                nxt_st.tmr = st_ff.tmr + TMR_W'(1);
                if (st_ff.tmr == CAL_LAST) begin
                    nxt_st.tmr   = '0;
                    nxt_st.cal   = 1'b0;
                    nxt_st.state = ST_RUN;
                end
            end
            ST_RUN: begin
                fifo_flush     = 1'b0;
                nxt_st.clk_lvl = src_clk;
                nxt_st.clk_p   = src_clk;
                nxt_st.clk_n   = ~src_clk;
                // R11 data moves only on clock rise
                if (src_clk && !st_ff.clk_lvl && fifo_valid) begin
                    fifo_pop     = 1'b1;
                    nxt_st.dat_p = fifo_data;
                    nxt_st.dat_n = ~fifo_data;
                end else if (st_ff.dat_p == st_ff.dat_n) begin
                    nxt_st.dat_n = ~st_ff.dat_p;
                end
                // R2 divide recovered clock
                if (rec_rise) begin
                    if (st_ff.pre >= div_last) begin
                        nxt_st.pre = '0;
                        if (st_ff.rec_cnt != {CNT_W{1'b1}}) begin
                            nxt_st.rec_cnt = st_ff.rec_cnt + CNT_W'(1);
                        end
                    end else begin
                        nxt_st.pre = st_ff.pre + PRE_W'(1);
                    end
                end
                if (ref_rise) begin
                    if (st_ff.ref_cnt == LOCK_WIN_LAST) begin
                        nxt_st.ref_cnt = '0;
                        nxt_st.rec_cnt = '0;
                        // R3 R6 R14 set and clear by deviation
                        nxt_st.lock_lost_flag     = (dev > LOCK_THRESH);
                    end else begin
                        nxt_st.ref_cnt = st_ff.ref_cnt + CNT_W'(1);
                    end
                end
                // R4 periodic retry while unlocked
                if (st_ff.lock_lost_flag) begin
                    nxt_st.tmr = st_ff.tmr + TMR_W'(1);
                    if (st_ff.tmr == RETRY_LAST) begin
                        nxt_st.tmr   = '0;
                        nxt_st.reacq = 1'b1;
                        // R5 drift bounces inside limit
                        if (trim_try > PPM_LIMIT || trim_try < -PPM_LIMIT) begin
                            nxt_st.trim_down = ~st_ff.trim_down;
                            nxt_st.trim      = st_ff.trim_down ? (st_ff.trim + PPM_STEP)
                                                               : (st_ff.trim - PPM_STEP);
                        end else begin
                            nxt_st.trim = trim_try;
                        end
                    end
                end else begin
                    nxt_st.tmr = '0;
                end
            end
            default: begin
                nxt_st.state = ST_PDN;
            end
        endcase
        if (pd_s && st_ff.state != ST_PDN) begin
            nxt_st.state = ST_PDN;
            nxt_st.hold  = '0;
            nxt_st.cal   = 1'b0;
            nxt_st.tmr   = '0;
            // R7 flag low in power down
            nxt_st.lock_lost_flag   = 1'b0;
            // R8 pairs parked high
            nxt_st.clk_p = 1'b1;
            nxt_st.clk_n = 1'b1;
            nxt_st.dat_p = 1'b1;
            nxt_st.dat_n = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            st_ff       <= '0;
            st_ff.state <= ST_PDN;
            st_ff.clk_p <= 1'b1;
            st_ff.clk_n <= 1'b1;
            st_ff.dat_p <= 1'b1;
            st_ff.dat_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_lock_lost_flag        = st_ff.lock_lost_flag;
    assign o_recovered_clock_out_p = st_ff.clk_p;
    assign o_recovered_clock_out_n = st_ff.clk_n;
    assign o_data_out_p            = st_ff.dat_p;
    assign o_data_out_n            = st_ff.dat_n;
    assign o_calibrating           = st_ff.cal;
    assign o_reacquire             = st_ff.reacq;
    assign o_vco_trim_ppm          = st_ff.trim;

endmodule : cdrsv_top

// ==== testbench/cdrsv_props.sv ====
`timescale 1ns/100ps
module cdrsv_props #(
    parameter logic [cdrsv_pkg::CNT_W-1:0] LOCK_THRESH = cdrsv_pkg::LOCK_THRESH_DEF
) (
    input wire logic                               i_sys_clk,                // clock
    input wire logic                               i_srst,                   // reset
    input wire logic                               i_powerdown_calibrate_in, // power down pin
    input wire logic                               o_lock_lost_flag,         // loss of lock
    input wire logic                               o_recovered_clock_out_p,  // clock true
    input wire logic                               o_recovered_clock_out_n,  // clock complement
    input wire logic                               o_data_out_p,             // data true
    input wire logic                               o_data_out_n,             // data complement
    input wire logic                               o_calibrating,            // calibration
    input wire logic                               o_reacquire,              // retry pulse
    input wire logic signed [cdrsv_pkg::TRIM_W-1:0] o_vco_trim_ppm           // drift offset
);
    import cdrsv_pkg::*;

    logic [15:0] gap_ff;
    logic        seen_ff;
    logic [15:0] cal_ff;
    wire logic   parked = o_recovered_clock_out_p & o_recovered_clock_out_n & o_data_out_p & o_data_out_n;

    // cycles since last retry, and calibration length
    always_ff @(posedge i_sys_clk) begin
        if (i_srst || !o_lock_lost_flag) begin
            seen_ff <= 1'b0;
            gap_ff  <= 16'h0;
        end else if (o_reacquire) begin
            seen_ff <= 1'b1;
            gap_ff  <= 16'h0;
        end else begin
            gap_ff <= gap_ff + 16'h1;
        end
        cal_ff <= (o_calibrating && !i_srst) ? cal_ff + 16'h1 : 16'h0;
    end

    default clocking dc @(posedge i_sys_clk);
    endclocking
    default disable iff (i_srst);

    property p_pd_park;
        i_powerdown_calibrate_in [*4] |=> parked;
    endproperty
    a_pd_park: assert property (p_pd_park) else $error("pairs not parked");
    property p_pd_lol;
        i_powerdown_calibrate_in [*4] |=> !o_lock_lost_flag;
    endproperty
    a_pd_lol: assert property (p_pd_lol) else $error("lock lost flag high in power down");
    property p_pairs;
        (o_recovered_clock_out_p | o_recovered_clock_out_n) & (o_data_out_p | o_data_out_n);
    endproperty
    a_pairs: assert property (p_pairs) else $error("pair legs both low");
    property p_data_rise;
        $changed(o_data_out_p) && !parked && !$past(parked) |-> $rose(o_recovered_clock_out_p);
    endproperty
    a_data_rise: assert property (p_data_rise) else $error("data changed off clock rise");
    property p_reacq;
        o_reacquire |-> (o_lock_lost_flag || $past(o_lock_lost_flag)) ##1 !o_reacquire;
    endproperty
    a_reacq: assert property (p_reacq) else $error("bad retry pulse");
    property p_retry_gap;
        seen_ff |-> gap_ff < RETRY_CYC;
    endproperty
    a_retry_gap: assert property (p_retry_gap) else $error("retry pulse missing");
    property p_retry_at;
        o_reacquire && seen_ff |-> gap_ff == RETRY_CYC - 1;
    endproperty
    a_retry_at: assert property (p_retry_at) else $error("retry period wrong");
    property p_trim;
        o_vco_trim_ppm <= PPM_LIMIT && o_vco_trim_ppm >= -PPM_LIMIT;
    endproperty
    a_trim: assert property (p_trim) else $error("trim outside window");
    property p_trim_step;
        $changed(o_vco_trim_ppm) && o_vco_trim_ppm != 11'sh0 |->
            o_vco_trim_ppm - $past(o_vco_trim_ppm) == PPM_STEP || $past(o_vco_trim_ppm) - o_vco_trim_ppm == PPM_STEP;
    endproperty
    a_trim_step: assert property (p_trim_step) else $error("trim step wrong");
    property p_cal_len;
        $fell(o_calibrating) && !$past(i_powerdown_calibrate_in, 3) |-> cal_ff == CAL_CYC;
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
    property p_cal_lol;
        o_calibrating |-> !o_lock_lost_flag;
    endproperty
    a_cal_lol: assert property (p_cal_lol) else $error("lock lost flag high in calibration");

    c_lol: cover property ($rose(o_lock_lost_flag));
    c_retry: cover property (o_reacquire && seen_ff);
    c_cal: cover property ($fell(o_calibrating));
endmodule : cdrsv_props

// ==== testbench/cdrsv_line_model.sv ====
`timescale 1ns/100ps
module cdrsv_line_model (
    input  wire logic i_sys_clk,  // system clock
    input  var  int   i_ref_half, // ref half period ns
    input  var  int   i_rec_half, // recovered half period ns
    input  wire logic i_en,       // offer data
    input  wire logic i_ready,    // design ready
    output logic      o_ref,      // reference clock
    output logic      o_rec,      // recovered clock
    output logic      o_valid,    // data valid
    output logic      o_data      // data bit
);
    logic took;

    initial begin
        o_ref = 1'b0;
        forever #(i_ref_half) o_ref = ~o_ref;
    end
    initial begin
        o_rec = 1'b0;
        #37;
        forever #(i_rec_half) o_rec = ~o_rec;
    end
    // hold word until taken, idle data toggles
    always @(posedge i_sys_clk) begin
        took = o_valid && i_ready;
        #1;
        if (took || o_valid !== 1'b1) begin
            o_valid = i_en && ($urandom_range(3) != 0);
            o_data  = o_valid ? 1'($urandom_range(1)) : ~o_data;
        end
    end
endmodule : cdrsv_line_model

// ==== testbench/cdrsv_top_tb.sv ====
`timescale 1ns/100ps
bind cdrsv_top cdrsv_props #(.LOCK_THRESH(LOCK_THRESH)) i_props (.i_sys_clk, .i_srst, .i_powerdown_calibrate_in,
    .o_lock_lost_flag, .o_recovered_clock_out_p, .o_recovered_clock_out_n, .o_data_out_p, .o_data_out_n,
    .o_calibrating, .o_reacquire, .o_vco_trim_ppm);
module cdrsv_top_tb;
    import cdrsv_pkg::*;
    localparam logic [CNT_W-1:0] THR = 10'h004;
    logic       clk, rst, pd, dp, en, valid, data, ready, lock_lost_flag, ckp, ckn, dtp, dtn, cal, reacq, ref_c, rec_c;
    logic       tk, b, pck;
    bit         e;
    logic [1:0] rate, ratio;
    int         ref_h, rec_h, errors, check_count, cyc, pops, pulses, rises, stalls, n, x;
    bit         q[$];

    cdrsv_top #(.LOCK_THRESH(THR)) i_dut (.i_sys_clk(clk), .i_srst(rst), .i_reference_clock_in(ref_c),
        .i_recov_clk(rec_c), .i_powerdown_calibrate_in(pd), .i_rate_select(rate), .i_ref_ratio(ratio),
        .i_data_present(dp), .i_rx_data(data), .i_rx_valid(valid), .o_rx_ready(ready), .o_lock_lost_flag(lock_lost_flag),
        .o_recovered_clock_out_p(ckp), .o_recovered_clock_out_n(ckn), .o_data_out_p(dtp), .o_data_out_n(dtn),
        .o_calibrating(cal), .o_reacquire(reacq), .o_vco_trim_ppm());
    cdrsv_line_model i_line (.i_sys_clk(clk), .i_ref_half(ref_h), .i_rec_half(rec_h), .i_en(en),
        .i_ready(ready), .o_ref(ref_c), .o_rec(rec_c), .o_valid(valid), .o_data(data));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : step

    // stream model: words queued on handshake, popped at clock rise
    always @(posedge clk) begin
        tk = valid && ready && !cal && !(ckp && ckn);
        b = data;
        cyc++;
        if (cyc == 90000) begin
            errors++;
            final_report();
        end
        #2;
        if (ckp && ckn) begin
            q.delete();
        end else if (ckp && !pck) begin
            rises++;
            if (q.size() > 0) begin
                e = q.pop_front();
                pops++;
                chk("data_pair", {dtp, dtn}, {e, !e});
            end
        end
        pck = ckp;
        pulses += reacq;
        stalls += !ready;
        if (tk) q.push_back(b);
    end

    task automatic lock_case(input logic [1:0] ra, input logic [1:0] rs, input int p);
        int w;
        int bad;
        w = 256 * p + 40;
        bad = $urandom_range(1) ? 250 : 160;
        ratio = ra;
        rate = rs;
        ref_h = 200 * p;
        rec_h = bad;
        step(3 * w);
        n = 64 * ref_h / (bad * p);
        x = n > 64 ? n - 64 : 64 - n;
        chk("lol_bad", lock_lost_flag, x > THR);
        chk("retry", pulses > 0, p >= 4);
        rec_h = 200;
        step(5);
        chk("lol_hold", lock_lost_flag, 1'b1);
        step(2 * w);
        pulses = 0;
        step(w);
        chk("lol_good", lock_lost_flag, 1'b0);
        chk("no_retry", pulses, 0);
        $display("lock test ratio %0d rate %0d done", ra, rs);
    endtask : lock_case

    task automatic pd_test(input int hold, input int cal_exp);
        en = 1'b0;
        for (n = 0; n < 400 && (valid || q.size() > 0); n++) step(1);
        chk("drained", q.size(), 0);
        pd = 1'b1;
        step(hold);
        chk("parked", {ckp, ckn, dtp, dtn}, 4'hf);
        chk("lol_pd", lock_lost_flag, 1'b0);
        pd = 1'b0;
        n = 0;
        repeat (40) begin
            step(1);
            n += cal;
        end
        chk("cal_len", n, cal_exp);
        chk("lol_rel", lock_lost_flag, 1'b0);
        en = 1'b1;
        $display("power down test hold %0d done", hold);
    endtask : pd_test

    initial begin
        {rst, pd, dp, en} = 4'hc;
        {errors, check_count, cyc, pops, pulses, rises, stalls} = '0;
        rate = RATE_DIV16;
        ratio = RATIO_16;
        ref_h = 200;
        rec_h = 200;
        pck = 1'b1;
        void'($urandom(29513));
        step(10);
        rst = 1'b0;
        step(15);
        pd = 1'b0;
        step(40);
        en = 1'b1;
        lock_case(RATIO_16, RATE_DIV16, 1);
        rec_h = 250;
        step(900);
        chk("lol_up", lock_lost_flag, 1'b1);
        pd_test(15, CAL_CYC);
        pd_test(5, 0);
        lock_case(RATIO_128, RATE_DIV16, 8);
        lock_case(RATIO_32, RATE_DIV4, 8);
        lock_case(RATIO_16, RATE_DIV2, 8);
        lock_case(RATIO_16, RATE_DIV1, 16);
        ref_h = 300;
        for (int d = 0; d < 2; d++) begin
            dp = d[0];
            step(20);
            rises = 0;
            step(1200);
            x = 120000 / (2 * (dp ? rec_h : ref_h));
            chk("clk_src", rises >= x - 1 && rises <= x + 1, 1'b1);
        end
        $display("clock source test done");
        chk("popped", pops > 0, 1'b1);
        chk("stalled", stalls > 0, 1'b1);
        final_report();
    end
endmodule : cdrsv_top_tb
